// *** verilog/flash_read_accelerator_defines.vh ***
// offsets, field positions, command codes and reset values of the flash read accelerator
`ifndef FLASH_READ_ACCELERATOR_DEFINES_VH
`define FLASH_READ_ACCELERATOR_DEFINES_VH

// register word indices on the register bus, decoded from address bits 3:2
`define OFF_MODE 2'h0
`define OFF_CMD 2'h1
`define OFF_STAT 2'h2
`define OFF_RES 2'h3

// flash_mode_reg fields
`define MODE_IRQEN 0
`define MODE_WS_LSB 8
`define MODE_WIDTH 24
`define MODE_RST 32'h00000000

// command word fields
`define CMD_KEY 8'h5A
`define CMD_KEY_LSB 24
`define CMD_ARG_LSB 8

// command codes
`define C_GETD 8'h00
`define C_WP 8'h01
`define C_WPL 8'h02
`define C_EWP 8'h03
`define C_EWPL 8'h04
`define C_EA 8'h05
`define C_SLB 8'h08
`define C_CLB 8'h09
`define C_GLB 8'h0A
`define C_SGPB 8'h0B
`define C_CGPB 8'h0C
`define C_GGPB 8'h0D
`define C_START_UNIQUE_ID_READ 8'h0E
`define C_SPUI 8'h0F
`define C_LAST 8'h10

// status register bits
`define STAT_RDY 0
`define STAT_CMDE 1
`define STAT_LOCKE 2

// bus responses
`define RESP_OK 2'b00
`define RESP_ERR 2'b10

`endif

// *** verilog/flash_read_accelerator.v ***
// flash controller front end: buffered array reads, latch buffer, commands
// Notes on behaviour
// - serve 32-bit system bus requests from flash
// - always clocked, no clock gating inside
// - interrupt only on ready flag rising edge
// - one plane of equal sized pages
// - two code line buffers, selected width
// - one data line buffer, selected width
// - page latch buffer, word writes anywhere
// - lock bit per region blocks write/erase
// - option bits set/cleared by commands
// - descriptor command returns flash organisation
// - byte, halfword and word reads supported
// - upper address bits ignored, array repeats
// - zero wait states gives single cycle access
// - 128-bit default, select bit gives 64-bit
// - sequential code fetches: first slow, rest fast
// - code buffers help non-consecutive fetches too
// - data miss fills whole aligned line
// - data hits need no consecutive reads
// - ready cleared on command, set at end
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_accelerator_defines.vh"
module flash_read_accelerator #(
  parameter FLASH_AW = 16,
  parameter PAGE_AW = 8,
  parameter LOCK_PG_LOG2 = 4,
  parameter NVM_BITS = 3,
  parameter [31:0] DESC_ID = 32'h000000A1, // arbitrary value
  parameter LOCK_RST = 0,
  parameter NVM_RST = 0
)(
  // clock and reset
  input wire mclk,
  input wire rstn,
  // register bus, write side
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // register bus, read side
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // flash space port
  input wire mem_req,
  input wire mem_we,
  input wire mem_fetch,
  input wire [1:0] mem_size,
  input wire [19:0] mem_addr,
  input wire [31:0] mem_wdata,
  output reg mem_ack_r,
  output reg [31:0] mem_rdata_r,
  // array read
  output reg arr_rd_r,
  output reg [FLASH_AW-5:0] arr_blk_r,
  input wire [127:0] arr_rdata,
  // array program
  output reg pgm_req_r,
  output reg [FLASH_AW-PAGE_AW-1:0] pgm_page_r,
  output reg pgm_erase_r,
  output reg pgm_all_r,
  input wire pgm_done,
  input wire [PAGE_AW-3:0] pgm_widx,
  output reg [31:0] pgm_wdata_r,
  // status
  output reg [NVM_BITS-1:0] nonvolatile_option_bits_r,
  output reg irq_r
);
  localparam PGW = FLASH_AW - PAGE_AW; // page number width
  localparam LKW = PGW - LOCK_PG_LOG2; // lock region index width
  localparam NLOCK = 1 << LKW;
  localparam LW = FLASH_AW - 3; // line index in 8-byte units
  localparam NVW = (NVM_BITS > 1) ? $clog2(NVM_BITS) : 1;
  localparam [31:0] FLASH_BYTES = 32'h00000001 << FLASH_AW;
  localparam [31:0] PAGE_BYTES = 32'h00000001 << PAGE_AW;
  localparam [31:0] REG_BYTES = 32'h00000001 << (PAGE_AW + LOCK_PG_LOG2);
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_MISS = 3'b010;
  localparam [2:0] S_PREF = 3'b100;
  localparam [NLOCK-1:0] LOCK_INIT = LOCK_RST; // lock bits after reset
  localparam [NVM_BITS-1:0] NVM_INIT = NVM_RST; // option bits after reset
  localparam [31:0] MODE_INIT = `MODE_RST; // mode word after reset

  // mode and command state
  reg [3:0] read_wait_states_r;
  reg access_width_select_r;
  reg irqen_r;
  reg command_ready_flag_r;
  reg ready_nxt;
  reg cmde_r;
  reg locke_r;
  reg done_r; // immediate command finishes next cycle
  reg busy_r; // waiting for the array to program
  reg uid_r; // unique id read in progress
  reg lk_after_r;
  reg [NLOCK-1:0] lock_r;
  reg res_desc_r;
  reg [31:0] res0_r;
  reg [7:0] idx_r;
  reg [31:0] res_w;
  reg [31:0] mode_rd;
  // register bus holding state
  reg aw_held_r;
  reg [7:0] awa_r;
  reg w_held_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  // read path state
  reg [2:0] st_r;
  reg [3:0] cnt_r;
  reg [LW-1:0] pl_r;
  reg [3:0] pa_r;
  reg [1:0] psz_r;
  reg pfetch_r;
  reg pf_pend_r;
  reg [LW-1:0] pf_line_r;
  reg cur_r; // code buffer that served last
  reg bufw_r; // width the buffers were filled at
  reg [127:0] cb0_r, cb1_r, db_r;
  reg [LW-1:0] ct0_r, ct1_r, dt_r;
  reg cv0_r, cv1_r, dv_r;
  reg [31:0] latch_r [0:(1<<(PAGE_AW-2))-1]; // write-only page latch
  reg hit;
  reg [1:0] hwho;
  reg [127:0] hline;

  // write decode
  wire wr_go = aw_held_r & w_held_r & ~bvalid;
  wire wr_map = (awa_r[7:4] == 4'h0);
  wire [1:0] wsel = awa_r[3:2];
  wire [31:0] wmask = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
  wire [31:0] mode_new = (mode_rd & ~wmask) | (wd_r & wmask);
  wire cmd_wr = wr_go & wr_map & (wsel == `OFF_CMD);
  wire [7:0] code = wd_r[7:0];
  wire [PGW-1:0] pg = wd_r[`CMD_ARG_LSB +: PGW];
  wire [LKW-1:0] rg = pg[PGW-1:LOCK_PG_LOG2];
  wire [NVW-1:0] nvi = wd_r[`CMD_ARG_LSB +: NVW];
  wire code_ok = (code <= `C_EA) | ((code >= `C_SLB) & (code <= `C_LAST));
  wire cmd_go = cmd_wr & (wd_r[`CMD_KEY_LSB +: 8] == `CMD_KEY) & code_ok &
                (uid_r ? (code == `C_SPUI) : command_ready_flag_r);
  wire is_pgm = (code >= `C_WP) & (code <= `C_EWPL);
  wire lk_viol = cmd_go & ((is_pgm & lock_r[rg]) | ((code == `C_EA) & (|lock_r)));
  // read decode
  wire rd_go = arvalid & arready;
  wire rd_map = (araddr[7:4] == 4'h0);
  wire stat_rd = rd_go & rd_map & (araddr[3:2] == `OFF_STAT);
  wire res_rd = rd_go & rd_map & (araddr[3:2] == `OFF_RES);

  // flash space address, wrapped to the array size
  wire [FLASH_AW-1:0] wa = mem_addr[FLASH_AW-1:0];
  wire [LW-1:0] li = access_width_select_r ? wa[FLASH_AW-1:3] :
                     {wa[FLASH_AW-1:4], 1'b0};
  wire [LW-1:0] step = access_width_select_r ? {{(LW-1){1'b0}}, 1'b1} :
                       {{(LW-2){1'b0}}, 2'b10};
  wire acc = mem_req & ~mem_ack_r; // ack cycle blocks a second take
  // 64-bit mode keeps only the addressed half, in the low bits
  wire [127:0] fill = access_width_select_r ?
    {64'h0, (pl_r[0] ? arr_rdata[127:64] : arr_rdata[63:0])} : arr_rdata;
  wire nxt_in = (cv0_r & (ct0_r == pf_line_r)) | (cv1_r & (ct1_r == pf_line_r));

  // pick the lane of a line for the given address and size
  function [31:0] lane;
    input [127:0] ln;
    input [3:0] a;
    input w64;
    input [1:0] sz;
    reg [31:0] w;
    begin
      w = w64 ? ln[32*a[2] +: 32] : ln[32*a[3:2] +: 32];
      w = w >> {a[1:0], 3'b000};
      case (sz)
        2'b00: lane = {24'h000000, w[7:0]};
        2'b01: lane = {16'h0000, w[15:0]};
        default: lane = w;
      endcase
    end
  endfunction

  // hit lookup across all three line buffers
  always @*
  begin
    hit = 1'b0;
    hwho = 2'd0;
    hline = db_r;
    if (cv0_r && ct0_r == li)
    begin
      hit = 1'b1;
      hwho = 2'd1;
      hline = cb0_r;
    end
    else if (cv1_r && ct1_r == li)
    begin
      hit = 1'b1;
      hwho = 2'd2;
      hline = cb1_r;
    end
    else if (dv_r && dt_r == li)
    begin
      hit = 1'b1;
      hwho = 2'd3;
      hline = db_r;
    end
  end

  // readable views of mode and result registers
  always @*
  begin
    mode_rd = 32'h00000000;
    mode_rd[`MODE_IRQEN] = irqen_r;
    mode_rd[`MODE_WS_LSB +: 4] = read_wait_states_r;
    mode_rd[`MODE_WIDTH] = access_width_select_r;
    res_w = 32'h00000000;
    if (res_desc_r)
    begin
      case (idx_r)
        8'h00: res_w = DESC_ID;
        8'h01: res_w = FLASH_BYTES;
        8'h02: res_w = PAGE_BYTES;
        8'h03: res_w = 32'h00000001;
        8'h04: res_w = FLASH_BYTES;
        8'h05: res_w = NLOCK;
        default: res_w = (idx_r < NLOCK + 6) ? REG_BYTES : 32'h00000000;
      endcase
    end
    else if (idx_r == 8'h00)
      res_w = res0_r;
  end

  // ready flag: an accepted command clears it, completion sets it
  always @*
  begin
    ready_nxt = command_ready_flag_r;
    if (cmd_go)
      ready_nxt = 1'b0;
    if (done_r | (busy_r & pgm_done))
      ready_nxt = 1'b1;
  end

  // register bus slave, command engine and flags
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `RESP_OK;
      rdata <= 32'h00000000;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      read_wait_states_r <= MODE_INIT[`MODE_WS_LSB +: 4];
      access_width_select_r <= MODE_INIT[`MODE_WIDTH];
      irqen_r <= MODE_INIT[`MODE_IRQEN];
      command_ready_flag_r <= 1'b1;
      cmde_r <= 1'b0;
      locke_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      uid_r <= 1'b0;
      lk_after_r <= 1'b0;
      lock_r <= LOCK_INIT;
      nonvolatile_option_bits_r <= NVM_INIT;
      res_desc_r <= 1'b0;
      res0_r <= 32'h00000000;
      idx_r <= 8'h00;
      pgm_req_r <= 1'b0;
      pgm_page_r <= {PGW{1'b0}};
      pgm_erase_r <= 1'b0;
      pgm_all_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      pgm_req_r <= 1'b0;
      // address and data may arrive in either order
      if (awvalid & awready)
      begin
        aw_held_r <= 1'b1;
        awa_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid & wready)
      begin
        w_held_r <= 1'b1;
        wd_r <= wdata;
        ws_r <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= wr_map ? `RESP_OK : `RESP_ERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (bvalid & bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (wr_go & wr_map & (wsel == `OFF_MODE))
      begin
        irqen_r <= mode_new[`MODE_IRQEN];
        read_wait_states_r <= mode_new[`MODE_WS_LSB +: 4];
        access_width_select_r <= mode_new[`MODE_WIDTH];
      end
      // one read at a time; status and result reads have side effects
      if (rd_go)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= rd_map ? `RESP_OK : `RESP_ERR;
        case (araddr[3:2])
          `OFF_MODE: rdata <= mode_rd;
          `OFF_STAT: rdata <= {29'h00000000, locke_r, cmde_r, command_ready_flag_r};
          `OFF_RES: rdata <= res_w;
          default: rdata <= 32'h00000000; // command register is write-only
        endcase
        if (!rd_map)
          rdata <= 32'h00000000;
      end
      if (rvalid & rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
      if (res_rd && idx_r != 8'hFF)
        idx_r <= idx_r + 8'h01;
      // a new error wins over a clear by the status read in the same cycle
      cmde_r <= (cmde_r & ~stat_rd) | (cmd_wr & ~cmd_go);
      locke_r <= (locke_r & ~stat_rd) | lk_viol;
      command_ready_flag_r <= ready_nxt;
      irq_r <= irqen_r & ready_nxt & ~command_ready_flag_r;
      if (busy_r & pgm_done)
      begin
        busy_r <= 1'b0;
        if (lk_after_r)
          lock_r[pgm_page_r[PGW-1:LOCK_PG_LOG2]] <= 1'b1;
      end
      if (cmd_go)
      begin
        res_desc_r <= 1'b0;
        res0_r <= 32'h00000000;
        idx_r <= 8'h00;
        done_r <= 1'b1;
        case (code)
          `C_GETD: res_desc_r <= 1'b1;
          `C_WP, `C_WPL, `C_EWP, `C_EWPL, `C_EA:
          begin
            if (!lk_viol)
            begin
              done_r <= 1'b0;
              busy_r <= 1'b1;
              pgm_req_r <= 1'b1;
              pgm_page_r <= pg;
              pgm_all_r <= (code == `C_EA);
              pgm_erase_r <= (code == `C_EWP) | (code == `C_EWPL);
              lk_after_r <= (code == `C_WPL) | (code == `C_EWPL);
            end
          end
          `C_SLB: lock_r[rg] <= 1'b1;
          `C_CLB: lock_r[rg] <= 1'b0;
          `C_GLB: res0_r <= {{(32-NLOCK){1'b0}}, lock_r};
          `C_SGPB:
            if (nvi < NVM_BITS)
              nonvolatile_option_bits_r[nvi] <= 1'b1;
          `C_CGPB:
            if (nvi < NVM_BITS)
              nonvolatile_option_bits_r[nvi] <= 1'b0;
          `C_GGPB: res0_r <= {{(32-NVM_BITS){1'b0}}, nonvolatile_option_bits_r};
          `C_START_UNIQUE_ID_READ:
          begin
            done_r <= 1'b0;
            uid_r <= 1'b1;
          end
          `C_SPUI: uid_r <= 1'b0;
          default: res0_r <= 32'h00000000; // calibration word reads zero
        endcase
      end
    end
  end

  // latch buffer drain toward the array; no reset, it is storage
  always @(posedge mclk)
  begin
    if (mem_req & mem_we & ~mem_ack_r & st_r[0])
      latch_r[wa[PAGE_AW-1:2]] <= mem_wdata;
    pgm_wdata_r <= latch_r[pgm_widx];
  end

  // read path: hit service, miss fill with wait states, prefetch
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      pl_r <= {LW{1'b0}};
      pa_r <= 4'h0;
      psz_r <= 2'b00;
      pfetch_r <= 1'b0;
      pf_pend_r <= 1'b0;
      pf_line_r <= {LW{1'b0}};
      cur_r <= 1'b0;
      bufw_r <= 1'b0;
      cv0_r <= 1'b0;
      cv1_r <= 1'b0;
      dv_r <= 1'b0;
      cb0_r <= 128'h0;
      cb1_r <= 128'h0;
      db_r <= 128'h0;
      ct0_r <= {LW{1'b0}};
      ct1_r <= {LW{1'b0}};
      dt_r <= {LW{1'b0}};
      mem_ack_r <= 1'b0;
      mem_rdata_r <= 32'h00000000;
      arr_rd_r <= 1'b0;
      arr_blk_r <= {(FLASH_AW-4){1'b0}};
    end
    else
    begin
      mem_ack_r <= 1'b0;
      case (st_r)
        S_IDLE:
        begin
          if (acc & mem_we)
            mem_ack_r <= 1'b1;
          else if (acc & hit)
          begin
            mem_ack_r <= 1'b1;
            mem_rdata_r <= lane(hline, wa[3:0], access_width_select_r, mem_size);
            if (mem_fetch && hwho != 2'd3)
            begin
              cur_r <= (hwho == 2'd2);
              pf_pend_r <= 1'b1;
              pf_line_r <= li + step;
            end
          end
          else if (acc)
          begin
            arr_rd_r <= 1'b1;
            arr_blk_r <= li[LW-1:1];
            pl_r <= li;
            pa_r <= wa[3:0];
            psz_r <= mem_size;
            pfetch_r <= mem_fetch;
            cnt_r <= read_wait_states_r;
            st_r <= S_MISS;
          end
          else if (pf_pend_r)
          begin
            pf_pend_r <= 1'b0;
            if (!nxt_in)
            begin
              arr_rd_r <= 1'b1;
              arr_blk_r <= pf_line_r[LW-1:1];
              pl_r <= pf_line_r;
              cnt_r <= read_wait_states_r;
              st_r <= S_PREF;
            end
          end
        end
        S_MISS, S_PREF:
        begin
          if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
          else
          begin
            arr_rd_r <= 1'b0;
            st_r <= S_IDLE;
            if (st_r[1])
            begin
              mem_ack_r <= 1'b1;
              mem_rdata_r <= lane(fill, pa_r, access_width_select_r, psz_r);
            end
            if (st_r[1] & ~pfetch_r)
            begin
              db_r <= fill;
              dt_r <= pl_r;
              dv_r <= 1'b1;
            end
            else
            begin
              // the buffer not serving now takes the line
              if (cur_r)
              begin
                cb0_r <= fill;
                ct0_r <= pl_r;
                cv0_r <= 1'b1;
              end
              else
              begin
                cb1_r <= fill;
                ct1_r <= pl_r;
                cv1_r <= 1'b1;
              end
              if (st_r[1])
              begin
                cur_r <= ~cur_r;
                pf_pend_r <= 1'b1;
                pf_line_r <= pl_r + step;
              end
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
      // lines of the old width are stale after a width change
      if (access_width_select_r != bufw_r)
      begin
        bufw_r <= access_width_select_r;
        cv0_r <= 1'b0;
        cv1_r <= 1'b0;
        dv_r <= 1'b0;
        pf_pend_r <= 1'b0;
      end
    end
  end
endmodule // flash_read_accelerator
`default_nettype wire

// *** verification/flash_read_accelerator_properties.sv ***
// port-level assertions for the flash read accelerator
`timescale 1ns/1ps
`default_nettype none
module flash_read_accelerator_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register bus
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // flash side
  input wire logic mem_req,
  input wire logic mem_ack_r,
  input wire logic arr_rd_r,
  input wire logic pgm_req_r,
  input wire logic irq_r
);
  // one clock domain, so clocking and reset are shared
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // interrupt is an edge event, never a level
  AST_IRQ_PULSE: assert property (irq_r |=> !irq_r)
    else $error("irq stayed high");
  AST_ACK_PULSE: assert property (mem_ack_r |=> !mem_ack_r)
    else $error("ack longer than a cycle");
  // an answer needs a request held in the cycle before
  AST_ACK_CAUSE: assert property (mem_ack_r |-> $past(mem_req))
    else $error("ack without request");
  // an array read ends within 17 cycles; the largest wait count of 15 keeps it to 16
  AST_ARR_BOUND: assert property ($rose(arr_rd_r) |-> ##[1:17] !arr_rd_r)
    else $error("array read never ends");
  AST_R_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_AR_BUSY: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  AST_B_AFTER: assert property ($rose(bvalid) |-> !awready && !wready)
    else $error("write response without take");
  AST_PGM_PULSE: assert property (pgm_req_r |=> !pgm_req_r)
    else $error("program request held");
  // main scenarios
  cover property ($rose(arr_rd_r) ##[1:17] mem_ack_r);
  cover property (irq_r);
  cover property (pgm_req_r);
endmodule // flash_read_accelerator_properties
bind flash_read_accelerator flash_read_accelerator_properties u_props (
  .mclk, .rstn, .awready, .wready, .bvalid, .bresp, .bready, .arvalid, .arready,
  .rvalid, .rready, .rdata, .mem_req, .mem_ack_r, .arr_rd_r, .pgm_req_r, .irq_r);
`default_nettype wire

// *** verification/flash_array_model.sv ***
// behavioural flash array: block reads and program timing
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
  parameter PGM_CYC = 20 // program time, far shorter than a real array
)(
  // clock
  input wire logic mclk,
  // block read
  input wire logic arr_rd_r,
  input wire logic [11:0] arr_blk_r,
  output logic [127:0] arr_rdata,
  // programming
  input wire logic pgm_req_r,
  output logic pgm_done,
  output logic [5:0] pgm_widx
);
  int cnt = 0; // cycles left in a program operation
  logic [15:0] a; // byte address of one word
  initial
  begin
    pgm_done = 1'b0;
    pgm_widx = 6'h00;
  end
  // each word holds its address; outside a read the inverse shows, so stale data fails
  always @*
  begin
    for (int i = 0; i < 4; i++)
    begin
      a = {arr_blk_r, i[1:0], 2'b00};
      arr_rdata[32*i +: 32] = arr_rd_r ? {a ^ 16'h5A5A, a} : ~{a ^ 16'h5A5A, a};
    end
  end
  // program timer; the latch index sweeps freely
  always @(posedge mclk)
  begin
    pgm_widx <= pgm_widx + 6'h01;
    pgm_done <= (cnt == 1);
    if (pgm_req_r === 1'b1)
      cnt <= PGM_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule // flash_array_model
`default_nettype wire

// *** verification/tb_flash_read_accelerator.sv ***
// self-checking bench for the flash read accelerator
`timescale 1ns/1ps
`default_nettype none
module tb_flash_read_accelerator;
  localparam [31:0] ID = 32'h0000_1D5E; // descriptor id, arbitrary value
  // clock, reset and register bus
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  // flash space port
  logic mem_req = 1'b0;
  logic mem_we = 1'b0;
  logic mem_fetch = 1'b0;
  logic [1:0] mem_size = 2'h2;
  logic [19:0] mem_addr = 20'h0;
  logic [31:0] mem_wdata = 32'h0;
  wire mem_ack_r, arr_rd_r, pgm_req_r, pgm_erase_r, pgm_all_r, pgm_done, irq_r;
  wire [31:0] mem_rdata_r, pgm_wdata_r;
  wire [11:0] arr_blk_r;
  wire [127:0] arr_rdata;
  wire [7:0] pgm_page_r;
  wire [5:0] pgm_widx;
  wire [2:0] nonvolatile_option_bits_r;
  // bookkeeping
  int n_mismatch = 0;
  int n_checks = 0;
  logic [31:0] n_irq = 32'h0; // interrupt pulses
  logic [31:0] n_pgm = 32'h0; // program requests
  logic [7:0] pg; // page of the last program request
  logic [31:0] d; // last read value
  logic [31:0] lat; // edges until a flash answer
  logic [1:0] r; // last bus response
  logic [19:0] ad; // flash address
  logic [31:0] desc [8] = '{ID, 32'h0001_0000, 32'h0000_0100, 32'h1,
    32'h0001_0000, 32'h10, 32'h0000_1000, 32'h0000_1000};
  flash_read_accelerator #(.DESC_ID(ID)) dut (
    .mclk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .mem_req, .mem_we, .mem_fetch, .mem_size, .mem_addr, .mem_wdata,
    .mem_ack_r, .mem_rdata_r, .arr_rd_r, .arr_blk_r, .arr_rdata, .pgm_req_r,
    .pgm_page_r, .pgm_erase_r, .pgm_all_r, .pgm_done, .pgm_widx, .pgm_wdata_r,
    .nonvolatile_option_bits_r, .irq_r);
  flash_array_model u_array (.mclk, .arr_rd_r, .arr_blk_r, .arr_rdata, .pgm_req_r,
    .pgm_done, .pgm_widx);
  // 250 MHz clock
  initial
    forever #2 mclk = ~mclk;
  // count pulses at the edges where they are sampled
  always @(posedge mclk)
  begin
    if (irq_r === 1'b1)
      n_irq = n_irq + 32'h1;
    if (pgm_req_r === 1'b1)
      n_pgm = n_pgm + 32'h1;
    if (pgm_req_r === 1'b1)
      pg = pgm_page_r;
  end
  // word the model stores at an aligned address
  function automatic logic [31:0] pat(input logic [19:0] a);
    pat = {a[15:0] ^ 16'h5A5A, a[15:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bus write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ad_done, wd_done;
    ad_done = 1'b0;
    wd_done = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad_done && wd_done))
    begin
      @(posedge mclk);
      ad_done = ad_done | awready;
      wd_done = wd_done | wready;
      awvalid <= !ad_done;
      wvalid <= !wd_done;
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b1;
    @(posedge mclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  // bus read; ready comes late so the slave must hold its answer
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge mclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // flash access, held until answered; gap after it lets prefetch finish
  task automatic mem(input logic [19:0] a, input logic [1:0] sz, input logic f,
    input logic we, input logic [31:0] elat);
    mem_addr <= a;
    mem_size <= sz;
    mem_fetch <= f;
    mem_we <= we;
    mem_wdata <= 32'hCAFE_0001;
    mem_req <= 1'b1;
    lat = 32'h0;
    do
    begin
      @(posedge mclk);
      lat = lat + 32'h1;
    end
    while (mem_ack_r !== 1'b1);
    mem_req <= 1'b0;
    d = mem_rdata_r;
    if (elat != 0)
      chk(lat, elat);
    repeat (8) @(posedge mclk);
  endtask
  // keyed command, then its fixed settling time
  task automatic cmd(input logic [7:0] c, input logic [15:0] g, input int w);
    axw(8'h04, {8'h5A, g, c});
    repeat (w) @(posedge mclk);
  endtask
  // hang guard, far beyond the planned run
  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    axr(8'h00);
    chk(d, 32'h0);
    axr(8'h40);
    chk({30'h0, r}, 32'h2);
    axw(8'h40, 32'h0);
    chk({30'h0, r}, 32'h2);
    // no wait states: a miss fills the whole line at once
    mem(20'h00200, 2'h2, 1'b0, 1'b0, 32'h3);
    chk(d, pat(20'h00200));
    axw(8'h00, 32'h0000_0100);
    mem(20'h00208, 2'h2, 1'b0, 1'b0, 32'h2);
    mem(20'h00209, 2'h0, 1'b0, 1'b0, 32'h0);
    chk(d, (pat(20'h00208) >> 8) & 32'hFF);
    mem(20'h0020E, 2'h1, 1'b0, 1'b0, 32'h0);
    chk(d, pat(20'h0020C) >> 16);
    mem(20'h10204, 2'h2, 1'b0, 1'b0, 32'h2);
    chk(d, pat(20'h00204));
    // code run: slow once, then each next line is already fetched
    for (int k = 0; k < 5; k++)
    begin
      ad = 20'h00600 + 20'(4 * k + 8 * (k / 2));
      mem(ad, 2'h2, 1'b1, 1'b0, (k == 0) ? 32'h4 : 32'h2);
      chk(d, pat(ad));
    end
    // narrow lines: the third word lies in a new line
    axw(8'h00, 32'h0100_0100);
    for (int k = 0; k < 3; k++)
    begin
      mem(20'h00800 + 20'(4 * k), 2'h2, 1'b0, 1'b0, (k == 1) ? 32'h2 : 32'h4);
      chk(d, pat(20'h00800 + 20'(4 * k)));
    end
    // commands with the ready interrupt enabled
    axw(8'h00, 32'h0000_0001);
    cmd(8'h00, 16'h0, 4);
    chk(n_irq, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      axr(8'h0C);
      chk(d, desc[k]);
    end
    axw(8'h04, 32'hA500_0000);
    axr(8'h08);
    chk(d, 32'h3);
    cmd(8'h08, 16'h3, 4);
    cmd(8'h0A, 16'h0, 4);
    axr(8'h0C);
    chk(d, 32'h1);
    cmd(8'h01, 16'h5, 4);
    axr(8'h08);
    chk(d, 32'h5);
    chk(n_pgm, 32'h0);
    cmd(8'h09, 16'h3, 4);
    mem(20'hF4044, 2'h2, 1'b0, 1'b1, 32'h0);
    do @(posedge mclk); while (pgm_widx !== 6'h11);
    @(posedge mclk);
    chk(pgm_wdata_r, 32'hCAFE_0001);
    cmd(8'h01, 16'h5, 30);
    chk(n_pgm, 32'h1);
    chk({22'h0, pgm_erase_r, pgm_all_r, pg}, 32'h5);
    axr(8'h08);
    chk(d, 32'h1);
    cmd(8'h0B, 16'h1, 4);
    chk({29'h0, nonvolatile_option_bits_r}, 32'h2);
    cmd(8'h0C, 16'h1, 4);
    chk({29'h0, nonvolatile_option_bits_r}, 32'h0);
    // unique-id start leaves ready low until its stop
    lat = n_irq;
    cmd(8'h0E, 16'h0, 4);
    axr(8'h08);
    chk(d, 32'h0);
    cmd(8'h0F, 16'h0, 4);
    chk(n_irq, lat + 32'h1);
    conclude();
  end
endmodule // tb_flash_read_accelerator
`default_nettype wire
